// ### rhd_pkg.sv
/*
 * Constants of the root hub descriptor register pair: offsets, field
 * positions, write masks and reset values.
 * Assumes a 32-bit register port whose byte offsets come from the
 * controller's memory base address decode.
 */
package rhd_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] DESC_A_OFS = 8'h48;
	localparam logic [7:0] DESC_B_OFS = 8'h4C;

	// ==========================================================
	// Descriptor A fields
	localparam int A_GOOD_TIME_LSB = 24;
	localparam int A_NO_OC_PROTECT = 12;
	localparam int A_OC_REPORT_MODE = 11;
	localparam int A_COMPOUND_DEV = 10;
	localparam int A_NO_PWR_SWITCH = 9;
	localparam int A_PWR_SWITCH_MODE = 8;
	localparam int A_PORT_COUNT_LSB = 0;
	localparam logic [7:0] A_GOOD_TIME_RST = 8'hFF;
	localparam logic A_NO_OC_PROTECT_RST = 1'h0;
	localparam logic A_OC_REPORT_MODE_RST = 1'h1;
	localparam logic A_NO_PWR_SWITCH_RST = 1'h0;
	localparam logic A_PWR_SWITCH_MODE_RST = 1'h1;

	// ==========================================================
	// Descriptor B fields
	localparam int B_MASK_LSB = 16;
	localparam int B_REMOVABLE_LSB = 0;
	localparam logic [15:0] B_MASK_RST_BASE = 16'h0002;
	localparam logic [15:0] B_MASK_PORT2 = 16'h0004;
	localparam logic [15:0] B_REMOVABLE_RST = 16'h0000;
	// Bit 0 of each per-port field is reserved; bit 11 of the mask
	// is read-only.
	localparam logic [15:0] B_MASK_WR_MASK = 16'hF7FE;
	localparam logic [15:0] B_REMOVABLE_WR_MASK = 16'hFFFE;

	// ==========================================================
	// Port count limits
	localparam int PORTS_MAX = 2;
	localparam int PORTS_MIN = 1;

endpackage : rhd_pkg

// ### rhd_port_power.sv
/*
 * Per-port power switch state of the root hub ports.
 * Assumes the power commands are one-cycle pulses from logic on the
 * same clock.
 */
`timescale 1ns/1ps

module rhd_port_power #(
	parameter int NUM_PORTS = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic no_power_switching_i,
	input wire logic power_switch_mode_i,
	input wire logic [rhd_pkg::PORTS_MAX-1:0] port_power_mask_i,
	input wire logic global_set_i,
	input wire logic global_clr_i,
	input wire logic [rhd_pkg::PORTS_MAX-1:0] port_set_i,
	input wire logic [rhd_pkg::PORTS_MAX-1:0] port_clr_i,
	output logic [rhd_pkg::PORTS_MAX-1:0] port_power_o
);

	// ==========================================================
	// Power state
	// A set and a clear in the same cycle leave the port powered.
	logic [rhd_pkg::PORTS_MAX-1:0] power_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_q <= '0;
		end else begin
			for (int i = 0; i < rhd_pkg::PORTS_MAX; i++) begin
				if (i >= NUM_PORTS) begin
					power_q[i] <= 1'b0;
				end else if (no_power_switching_i) begin
					power_q[i] <= 1'b1; // [R3]
				end else if (!power_switch_mode_i) begin
					// Mask ignored in ganged mode. [R10]
					if (global_set_i) begin
						power_q[i] <= 1'b1; // [R5]
					end else if (global_clr_i) begin
						power_q[i] <= 1'b0; // [R5]
					end
				end else if (port_power_mask_i[i]) begin
					if (port_set_i[i]) begin
						power_q[i] <= 1'b1; // [R6]
					end else if (port_clr_i[i]) begin
						power_q[i] <= 1'b0; // [R6]
					end
				end else if (global_set_i) begin
					power_q[i] <= 1'b1; // [R7]
				end else if (global_clr_i) begin
					power_q[i] <= 1'b0; // [R7]
				end
			end
		end
	end

	assign port_power_o = power_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	always_on_a: assert property (no_power_switching_i |=> power_q[0]) // [R3]
		else $error("Port not powered without switching.");
	ganged_on_a: assert property (!no_power_switching_i && // [R5]
		!power_switch_mode_i && global_set_i |=> power_q[0])
		else $error("Ganged set did not power port.");
	ganged_off_a: assert property (!no_power_switching_i && // [R10]
		!power_switch_mode_i && global_clr_i && !global_set_i &&
		port_power_mask_i[0] |=> !power_q[0])
		else $error("Ganged clear ignored on masked port.");
	masked_port_a: assert property (!no_power_switching_i && // [R6]
		power_switch_mode_i && port_power_mask_i[0] && !port_set_i[0] &&
		!port_clr_i[0] |=> $stable(power_q[0]))
		else $error("Masked port followed global command.");
	unmasked_port_a: assert property (!no_power_switching_i && // [R7]
		power_switch_mode_i && !port_power_mask_i[0] && !global_set_i &&
		!global_clr_i |=> $stable(power_q[0]))
		else $error("Unmasked port followed port command.");

endmodule : rhd_port_power

// ### rhd_regs.sv
/*
 * Root hub descriptor A and B registers with the port power switch.
 * Assumes a 32-bit register port on the controller clock, driven by
 * the controller's base address decode; reads answer one cycle later.
 */
// Function
// [R1] Overcurrent mode bit 11: 0 collective, 1 per-port; valid when protection on.
// [R2] Compound device bit 10 always reads 0.
// [R3] No-power-switching bit 9: 1 means ports always powered.
// [R4] Switching mode bit 8 ignored while no-power-switching is set.
// [R5] Mode 0: all ports powered on and off together.
// [R6] Mode 1 with mask bit set: port obeys only per-port commands.
// [R7] Mode 1 with mask bit clear: port obeys only global commands.
// [R8] Port count field bits 7..0 reports ports, between 1 and 15.
// [R9] Driver software programs descriptor B at 4Ch during initialisation.
// [R10] Port power mask bits 31..16, ignored while switching mode is 0.
// [R11] Mask bit 0 reserved; bits 1 and 2 for ports 1 and 2.
// [R12] Removable bits 15..0: 0 removable, 1 not removable.
// [R13] Removable bit 0 reserved; bits 1 and 2 for ports 1 and 2.
// [R14] Descriptor B resets to zero except bit 17 set, bit 18 per build.
// [R15] Build parameter of one or two ports sets count and mask reset.
`timescale 1ns/1ps

module rhd_regs #(
	parameter int NUM_PORTS = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic global_set_i,
	input wire logic global_clr_i,
	input wire logic [rhd_pkg::PORTS_MAX-1:0] port_set_i,
	input wire logic [rhd_pkg::PORTS_MAX-1:0] port_clr_i,
	output logic [rhd_pkg::PORTS_MAX-1:0] port_power_o,
	output logic oc_per_port_o,
	output logic oc_protect_o,
	output logic [7:0] good_time_o
);

	// ==========================================================
	// Build constants
	localparam logic [7:0] PORT_COUNT = 8'(NUM_PORTS); // [R8] [R15]
	localparam logic [15:0] MASK_RST = (NUM_PORTS == rhd_pkg::PORTS_MAX) ?
		(rhd_pkg::B_MASK_RST_BASE | rhd_pkg::B_MASK_PORT2) :
		rhd_pkg::B_MASK_RST_BASE; // [R14] [R15]

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		return addr == ofs;
	endfunction : hit

	// ==========================================================
	// Descriptor A
	logic [7:0] good_time_q;
	logic no_oc_protect_q;
	logic oc_report_mode_q;
	logic no_power_switching_q;
	logic power_switch_mode_q;
	logic [31:0] desc_a_now;
	logic [31:0] desc_a_new;

	always_comb begin
		desc_a_now = '0;
		desc_a_now[rhd_pkg::A_GOOD_TIME_LSB +: 8] = good_time_q;
		desc_a_now[rhd_pkg::A_NO_OC_PROTECT] = no_oc_protect_q;
		desc_a_now[rhd_pkg::A_OC_REPORT_MODE] = oc_report_mode_q;
		desc_a_now[rhd_pkg::A_COMPOUND_DEV] = 1'b0; // [R2]
		desc_a_now[rhd_pkg::A_NO_PWR_SWITCH] = no_power_switching_q;
		desc_a_now[rhd_pkg::A_PWR_SWITCH_MODE] = power_switch_mode_q;
		desc_a_now[rhd_pkg::A_PORT_COUNT_LSB +: 8] = PORT_COUNT; // [R8]
	end

	assign desc_a_new = merge_bytes(desc_a_now, reg_wdata_i, reg_be_i);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			good_time_q <= rhd_pkg::A_GOOD_TIME_RST;
			no_oc_protect_q <= rhd_pkg::A_NO_OC_PROTECT_RST;
			oc_report_mode_q <= rhd_pkg::A_OC_REPORT_MODE_RST;
			no_power_switching_q <= rhd_pkg::A_NO_PWR_SWITCH_RST;
			power_switch_mode_q <= rhd_pkg::A_PWR_SWITCH_MODE_RST;
		end else if (reg_wr_i && hit(reg_addr_i, rhd_pkg::DESC_A_OFS)) begin
			good_time_q <= desc_a_new[rhd_pkg::A_GOOD_TIME_LSB +: 8];
			no_oc_protect_q <= desc_a_new[rhd_pkg::A_NO_OC_PROTECT];
			oc_report_mode_q <= desc_a_new[rhd_pkg::A_OC_REPORT_MODE]; // [R1]
			no_power_switching_q <= desc_a_new[rhd_pkg::A_NO_PWR_SWITCH];
			power_switch_mode_q <= desc_a_new[rhd_pkg::A_PWR_SWITCH_MODE];
		end
	end

	// Mode bit only counts while ports are switched at all.
	logic switch_mode_eff;
	assign switch_mode_eff = power_switch_mode_q && !no_power_switching_q; // [R4]

	// Overcurrent mode has no meaning when protection is absent.
	assign oc_per_port_o = oc_report_mode_q && !no_oc_protect_q; // [R1]
	assign oc_protect_o = !no_oc_protect_q;
	assign good_time_o = good_time_q;

	// ==========================================================
	// Descriptor B
	// Software writes it once at start-up to describe the board. [R9]
	logic [15:0] port_mask_q;
	logic [15:0] removable_q;
	logic [31:0] desc_b_now;
	logic [31:0] desc_b_new;

	assign desc_b_now = {port_mask_q, removable_q};
	assign desc_b_new = merge_bytes(desc_b_now, reg_wdata_i, reg_be_i);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_mask_q <= MASK_RST; // [R14]
			removable_q <= rhd_pkg::B_REMOVABLE_RST; // [R14]
		end else if (reg_wr_i && hit(reg_addr_i, rhd_pkg::DESC_B_OFS)) begin
			port_mask_q <= (desc_b_new[rhd_pkg::B_MASK_LSB +: 16] &
				rhd_pkg::B_MASK_WR_MASK) | (port_mask_q &
				~rhd_pkg::B_MASK_WR_MASK); // [R11]
			removable_q <= desc_b_new[rhd_pkg::B_REMOVABLE_LSB +: 16] &
				rhd_pkg::B_REMOVABLE_WR_MASK; // [R12] [R13]
		end
	end

	// ==========================================================
	// Read port
	// Unmapped offsets read zero and ignore writes.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			if (hit(reg_addr_i, rhd_pkg::DESC_A_OFS)) begin
				reg_rdata_o <= desc_a_now;
			end else if (hit(reg_addr_i, rhd_pkg::DESC_B_OFS)) begin
				reg_rdata_o <= desc_b_now;
			end else begin
				reg_rdata_o <= '0;
			end
		end
	end

	// ==========================================================
	// Port power switch
	// Mask bit n+1 steers port n; bit 0 has no port. [R11]
	rhd_port_power #(
		.NUM_PORTS(NUM_PORTS)
	) u_power (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.no_power_switching_i(no_power_switching_q),
		.power_switch_mode_i(switch_mode_eff),
		.port_power_mask_i(port_mask_q[rhd_pkg::PORTS_MAX:1]),
		.global_set_i(global_set_i),
		.global_clr_i(global_clr_i),
		.port_set_i(port_set_i),
		.port_clr_i(port_clr_i),
		.port_power_o(port_power_o)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence read_a_s;
		reg_rd_i && hit(reg_addr_i, rhd_pkg::DESC_A_OFS);
	endsequence

	sequence read_b_s;
		reg_rd_i && hit(reg_addr_i, rhd_pkg::DESC_B_OFS);
	endsequence

	compound_zero_a: assert property (read_a_s |=> // [R2]
		!reg_rdata_o[rhd_pkg::A_COMPOUND_DEV])
		else $error("Compound device bit read as one.");
	port_count_a: assert property (read_a_s |=> // [R8]
		reg_rdata_o[7:0] == PORT_COUNT && reg_rdata_o[7:0] >= 8'h01 &&
		reg_rdata_o[7:0] <= 8'h0F)
		else $error("Port count read wrong.");
	mask_reserved_a: assert property (read_b_s |=> // [R11]
		!reg_rdata_o[rhd_pkg::B_MASK_LSB])
		else $error("Reserved mask bit read as one.");
	removable_rsvd_a: assert property (read_b_s |=> // [R13]
		!reg_rdata_o[rhd_pkg::B_REMOVABLE_LSB])
		else $error("Reserved removable bit read as one.");
	removable_wr_a: assert property (reg_wr_i && reg_be_i[0] && // [R12]
		hit(reg_addr_i, rhd_pkg::DESC_B_OFS) ##1 read_b_s |=>
		reg_rdata_o[2:1] == $past(reg_wdata_i[2:1], 2))
		else $error("Removable bits not stored.");
	oc_mode_a: assert property (reg_wr_i && reg_be_i[1] && // [R1]
		hit(reg_addr_i, rhd_pkg::DESC_A_OFS) |=> oc_per_port_o ==
		($past(reg_wdata_i[rhd_pkg::A_OC_REPORT_MODE]) &&
		!$past(reg_wdata_i[rhd_pkg::A_NO_OC_PROTECT])))
		else $error("Overcurrent mode shown while protection absent.");
	mode_ignored_a: assert property (no_power_switching_q |=> // [R4]
		&port_power_o[NUM_PORTS-1:0])
		else $error("Switch mode used while ports unswitched.");
	unmapped_a: assert property (reg_rd_i &&
		!hit(reg_addr_i, rhd_pkg::DESC_A_OFS) &&
		!hit(reg_addr_i, rhd_pkg::DESC_B_OFS) |=> reg_rdata_o == '0)
		else $error("Unmapped read returned data.");

endmodule : rhd_regs

// ### tb_rhd_regs.sv
/*
 * Self-checking testbench for rhd_regs with two ports.
 * Assumes rhd_pkg and the design files are compiled before it.
 */
`timescale 1ns/1ps

module tb_rhd_regs;
	// ==========================================================
	// Signals and models
	localparam int NP = 2;
	logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, global_set_i, global_clr_i;
	logic [7:0] reg_addr_i, good_time_o;
	logic [3:0] reg_be_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, a_m, b_m, r;
	logic [1:0] port_set_i, port_clr_i, port_power_o, pw;
	logic oc_per_port_o, oc_protect_o, chk_s, pend_r, pend_s;
	logic [31:0] rd_q[$];
	logic [11:0] st_q[$];
	int errors, checked, cycles, seed;

	rhd_regs #(.NUM_PORTS(NP)) rhd_regs_inst (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.global_set_i(global_set_i), .global_clr_i(global_clr_i),
		.port_set_i(port_set_i), .port_clr_i(port_clr_i),
		.port_power_o(port_power_o), .oc_per_port_o(oc_per_port_o),
		.oc_protect_o(oc_protect_o), .good_time_o(good_time_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ==========================================================
	// Drivers
	task drive(input logic w, rr, input logic [7:0] ad,
		input logic [3:0] be, input logic [31:0] d, input logic gs, gc,
		input logic [1:0] ps, pc, input logic cs);
		@(posedge clk_i);
		#2;
		reg_wr_i = w;
		reg_rd_i = rr;
		reg_addr_i = ad;
		reg_be_i = be;
		reg_wdata_i = d;
		global_set_i = gs;
		global_clr_i = gc;
		port_set_i = ps;
		port_clr_i = pc;
		chk_s = cs;
	endtask : drive

	function logic [31:0] merge(input logic [31:0] o, d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) if (be[i]) o[8*i +: 8] = d[8*i +: 8];
		return o;
	endfunction : merge

	// Reserved, read-only and port count bits are folded into the model.
	task wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
		if (ad == rhd_pkg::DESC_A_OFS)
			a_m = (merge(a_m, d, be) & 32'hFF001B00) | 32'(NP);
		if (ad == rhd_pkg::DESC_B_OFS)
			b_m = merge(b_m, d, be) & 32'hF7FEFFFE;
		// Unswitched ports turn on at the edge after the write, command or not.
		if (a_m[9])
			pw = 2'h3;
		drive(1'b1, 1'b0, ad, be, d, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0);
	endtask : wr

	task rd(input logic [7:0] ad);
		rd_q.push_back(ad == rhd_pkg::DESC_A_OFS ? a_m :
			ad == rhd_pkg::DESC_B_OFS ? b_m : 32'h0);
		drive(1'b0, 1'b1, ad, 4'h0, 32'h0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0);
	endtask : rd

	// Set wins over clear when both arrive together.
	task cmd(input logic gs, gc, input logic [1:0] ps, pc);
		for (int i = 0; i < 2; i++) begin
			if (a_m[9])
				pw[i] = 1'b1;
			else if (a_m[8] && b_m[17+i])
				pw[i] = ps[i] | (pw[i] & ~pc[i]);
			else
				pw[i] = gs | (pw[i] & ~gc);
		end
		st_q.push_back({a_m[31:24], a_m[11] & ~a_m[12], ~a_m[12], pw});
		drive(1'b0, 1'b0, 8'h00, 4'h0, 32'h0, gs, gc, ps, pc, 1'b1);
	endtask : cmd

	// ==========================================================
	// Checking
	task cmp_rd(input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value read data expected %h seen %h", e, s);
		end
	endtask : cmp_rd

	task cmp_st(input logic [11:0] e, s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value status expected %h seen %h", e, s);
		end
	endtask : cmp_st

	task end_of_test;
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test

	// A result is due one edge after the edge that took its request.
	always @(posedge clk_i) begin
		if (pend_r) cmp_rd(rd_q.pop_front(), reg_rdata_o);
		if (pend_s) cmp_st(st_q.pop_front(), {good_time_o, oc_per_port_o,
			oc_protect_o, port_power_o});
		pend_r = reg_rd_i;
		pend_s = chk_s;
		cycles++;
		if (cycles > 3000) begin
			errors++;
			end_of_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 90584;
		{errors, checked, cycles} = '0;
		{pend_r, pend_s, chk_s, rst_b_i, reg_wr_i, reg_rd_i} = '0;
		{reg_addr_i, reg_be_i, reg_wdata_i} = '0;
		{global_set_i, global_clr_i, port_set_i, port_clr_i} = '0;
		a_m = 32'hFF000900 | 32'(NP);
		b_m = 32'h00060000;
		pw = 2'h0;
		repeat (8) @(posedge clk_i);
		#2 rst_b_i = 1'b1;
		cmd(1'b0, 1'b0, 2'h0, 2'h0);
		rd(8'h48);
		rd(8'h4C);
		wr(8'h48, 4'hF, 32'hFFFFFFFF);
		wr(8'h4C, 4'hF, 32'hFFFFFFFF);
		rd(8'h48);
		rd(8'h4C);
		wr(8'h50, 4'hF, 32'h0);
		rd(8'h50);
		rd(8'h4C);
		wr(8'h4C, 4'hF, 32'h00060006);
		rd(8'h4C);
		wr(8'h48, 4'hF, 32'h00000100);
		wr(8'h4C, 4'hF, 32'h00020000);
		cmd(1'b1, 1'b0, 2'h0, 2'h0);
		cmd(1'b0, 1'b0, 2'h1, 2'h0);
		cmd(1'b0, 1'b1, 2'h0, 2'h0);
		cmd(1'b0, 1'b0, 2'h2, 2'h1);
		wr(8'h48, 4'hF, 32'h0);
		cmd(1'b1, 1'b0, 2'h0, 2'h0);
		cmd(1'b0, 1'b0, 2'h0, 2'h3);
		cmd(1'b0, 1'b1, 2'h0, 2'h0);
		for (int k = 0; k < 4; k++) begin
			wr(8'h48, 4'h2, 32'(k) << 11);
			cmd(1'b0, 1'b0, 2'h0, 2'h0);
		end
		repeat (20) begin
			r = $random(seed);
			wr(8'h48, r[3:0], $random(seed) & 32'hFFFFFDFF);
			wr(8'h4C, r[7:4], $random(seed));
			repeat (4) begin
				r = $random(seed);
				cmd(r[0], r[1], r[3:2], r[5:4]);
			end
			rd(8'h48);
			rd(8'h4C);
		end
		wr(8'h48, 4'hF, 32'h00000200);
		cmd(1'b0, 1'b1, 2'h0, 2'h3);
		drive(1'b0, 1'b0, 8'h00, 4'h0, 32'h0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0);
		repeat (2) @(posedge clk_i);
		end_of_test();
	end
endmodule : tb_rhd_regs
